// ---- logic/tx_ch1_bit3_pin_mux.sv ----
// role selection and data paths of the channel 1 bit 3 shared pin
//
// Overview of operation
// (R1) add bus enable decides the role first
// (R2) add bus: pin is data bit 3
// (R3) add bus byte latched on falling clock
// (R4) otherwise mode picks HDLC or mapper
// (R5) HDLC mode: pin is data bit 3
// (R6) HDLC mode: drive byte rate clock out
// (R7) HDLC byte sampled on our rising edge
// (R8) mapper mode: side port, add or drop
// (R9) side add: pin is positive data in
// (R10) side add: sample on port clock rise
// (R11) side drop: pin outputs positive data
// (R12) side drop: update on port clock fall
// (R13) drive pin only in side drop mode
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
module tx_ch1_bit3_pin_mux
   import pin_mux_pkg::*;
#(
   parameter int HALF_PERIOD = DIV_HALF
)
(
   // system side register port
   input  wire logic              clk,           // system clock
   input  wire logic              resetn,        // synchronous reset
   input  wire logic [ADDR_W-1:0] regAddr,       // register address
   input  wire logic [31:0]       regWrData,     // register write data
   input  wire logic              regWr,         // write strobe
   input  wire logic              regRd,         // read strobe
   output logic [31:0]            regRdData,     // read data, next cycle

   // shared pin
   input  wire logic              padIn,         // shared pin level in
   output logic                   padOut,        // shared pin drive value
   output logic                   padOe,         // shared pin drive enable

   // add bus, own clock domain
   input  wire logic              addBusClk,     // add bus clock
   input  wire logic [3:0]        addBusHi,      // add bus bits 7 to 4
   input  wire logic [2:0]        addBusLo,      // add bus bits 2 to 0

   // hdlc byte interface
   input  wire logic [3:0]        hdlcHi,        // hdlc bits 7 to 4
   input  wire logic [2:0]        hdlcLo,        // hdlc bits 2 to 0
   output logic                   hdlcByteClock, // hdlc byte clock out

   // side port pins
   input  wire logic              sideNegIn,     // negative data pin in
   output logic                   sideNegOut,    // negative data drive
   output logic                   sideNegOe,     // negative data enable
   input  wire logic              sideClkIn,     // port clock pin in
   output logic                   sideClkOut,    // port clock drive
   output logic                   sideClkOe,     // port clock enable

   // toward the core
   output logic [7:0]             addByte,       // captured add bus byte
   output logic                   addByteValid,  // one cycle pulse
   output logic [7:0]             hdlcByte,      // captured hdlc byte
   output logic                   hdlcByteValid, // one cycle pulse
   output logic                   sidePos,       // sampled positive data
   output logic                   sideNeg,       // sampled negative data
   output logic                   sideValid,     // one cycle pulse
   input  wire logic              dropPos,       // positive data to drop
   input  wire logic              dropNeg,       // negative data to drop
   output logic                   dropTake       // drop bits taken, pulse
);

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      // control register
      logic             addEn;
      logic             mapper;
      logic             drop;

      // two-flop synchronisers
      logic             padMeta;
      logic             padSync;
      logic [3:0]       hiMeta;
      logic [3:0]       hiSync;
      logic [2:0]       loMeta;
      logic [2:0]       loSync;
      logic             negMeta;
      logic             negSync;
      logic             sclkMeta;
      logic             sclkSync;
      logic             sclkPrev;
      logic             reqMeta;
      logic             reqSync;
      logic             ack;

      // divider and sample timing
      logic [DIV_W-1:0] divCnt;
      logic             genClk;
      logic [1:0]       riseDly;

      // captured samples
      logic [7:0]       addB;
      logic             addV;
      logic [7:0]       hdlcB;
      logic             hdlcV;
      logic             sPos;
      logic             sNeg;
      logic             sV;

      // drop data on the pins
      logic             dPos;
      logic             dNeg;
      logic             dTake;

      // counters and read data
      logic [15:0]      addCnt;
      logic [15:0]      hdlcCnt;
      logic [31:0]      rd;
   } state_t;

   state_t cur_ff;
   state_t nxt_cur;
   // decoded role and add bus handover
   role_t  role;
   logic   [7:0] busByte;
   logic   reqTgl;
   logic   [7:0] heldByte;
   logic   [31:0] ctrlWord;
   logic   [31:0] statusWord;

   localparam logic [DIV_W-1:0] HALF_M1 = DIV_W'(HALF_PERIOD - 1);

   // -------------------------------------------------------------
   // role decode
   // -------------------------------------------------------------
   always_comb begin
      // add bus enable overrides every mode bit
      if (cur_ff.addEn) begin
         role = ROLE_ADD_BUS;  // [R1]
      end else if (!cur_ff.mapper) begin
         role = ROLE_HDLC;  // [R4]
      end else if (cur_ff.drop) begin
         role = ROLE_SIDE_DROP;  // [R8]
      end else begin
         role = ROLE_SIDE_ADD;  // [R8]
      end
   end

   // raw add bus byte, pin in bit 3
   assign busByte = {addBusHi, padIn, addBusLo};  // [R2]

   // -------------------------------------------------------------
   // add bus clock domain
   // -------------------------------------------------------------
   // toggle handshake: the held byte stays put until the ack toggle
   // returns, so all eight bits cross together
   add_bus_capture u_capture (
      .addBusClk (addBusClk),
      .resetn    (resetn),
      .captureEn (cur_ff.addEn),
      .busByte   (busByte),
      .ackTgl    (cur_ff.ack),
      .reqTgl    (reqTgl),
      .heldByte  (heldByte)
   );

   // -------------------------------------------------------------
   // register words
   // -------------------------------------------------------------
   always_comb begin
      // control readback
      ctrlWord                 = 32'h0000_0000;
      ctrlWord[CTRL_ADD_EN]    = cur_ff.addEn;
      ctrlWord[CTRL_MAPPER]    = cur_ff.mapper;
      ctrlWord[CTRL_DROP]      = cur_ff.drop;

      // live status
      statusWord               = 32'h0000_0000;
      statusWord[ST_ROLE_LSB +: 2] = role;
      statusWord[ST_PAD]       = cur_ff.padSync;
      statusWord[ST_SIDE_POS]  = cur_ff.sPos;
      statusWord[ST_SIDE_NEG]  = cur_ff.sNeg;
      statusWord[ST_ADD_LSB +: 8]  = cur_ff.addB;
      statusWord[ST_HDLC_LSB +: 8] = cur_ff.hdlcB;
   end

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      nxt_cur          = cur_ff;
      nxt_cur.addV     = 1'b0;
      nxt_cur.hdlcV    = 1'b0;
      nxt_cur.sV       = 1'b0;
      nxt_cur.dTake    = 1'b0;
      nxt_cur.rd       = 32'h0000_0000;

      // ----------------------------------------------------------
      // pin synchronisers
      // ----------------------------------------------------------
      nxt_cur.padMeta  = padIn;
      nxt_cur.padSync  = cur_ff.padMeta;
      nxt_cur.hiMeta   = hdlcHi;
      nxt_cur.hiSync   = cur_ff.hiMeta;
      nxt_cur.loMeta   = hdlcLo;
      nxt_cur.loSync   = cur_ff.loMeta;

      // side port data and clock pins
      nxt_cur.negMeta  = sideNegIn;
      nxt_cur.negSync  = cur_ff.negMeta;
      nxt_cur.sclkMeta = sideClkIn;
      nxt_cur.sclkSync = cur_ff.sclkMeta;
      nxt_cur.sclkPrev = cur_ff.sclkSync;

      // add bus request toggle
      nxt_cur.reqMeta  = reqTgl;
      nxt_cur.reqSync  = cur_ff.reqMeta;

      // ----------------------------------------------------------
      // clock divider for the byte clock and the drop port clock
      // ----------------------------------------------------------
      // only one of the two is ungated at a time, so they share it
      nxt_cur.riseDly  = {cur_ff.riseDly[0], 1'b0};
      if (cur_ff.divCnt == HALF_M1) begin
         nxt_cur.divCnt = '0;
         nxt_cur.genClk = ~cur_ff.genClk;  // [R6]
         if (!cur_ff.genClk) begin
            nxt_cur.riseDly[0] = 1'b1;
         end else if (role == ROLE_SIDE_DROP) begin
            // falling edge of the port clock
            nxt_cur.dPos  = dropPos;  // [R11] [R12]
            nxt_cur.dNeg  = dropNeg;  // [R12]
            nxt_cur.dTake = 1'b1;
         end
      end else begin
         nxt_cur.divCnt = cur_ff.divCnt + DIV_W'(1);
      end

      // ----------------------------------------------------------
      // add bus byte arriving from the link domain
      // ----------------------------------------------------------
      // bus bytes that arrive while a handshake is in flight are not latched
      if (cur_ff.reqSync != cur_ff.ack) begin
         nxt_cur.ack    = cur_ff.reqSync;
         nxt_cur.addB   = heldByte;  // [R3]
         nxt_cur.addV   = 1'b1;
         nxt_cur.addCnt = cur_ff.addCnt + 16'h0001;
      end

      // ----------------------------------------------------------
      // hdlc byte, synced pins reflect the rising edge level
      // ----------------------------------------------------------
      // pins were captured at the edge that raised the byte clock
      if (role == ROLE_HDLC && cur_ff.riseDly[1]) begin
         nxt_cur.hdlcB   = {cur_ff.hiSync, cur_ff.padSync, cur_ff.loSync};  // [R5] [R7]
         nxt_cur.hdlcV   = 1'b1;
         nxt_cur.hdlcCnt = cur_ff.hdlcCnt + 16'h0001;
      end

      // ----------------------------------------------------------
      // side port add, rising edge of the incoming port clock
      // ----------------------------------------------------------
      // clock and data share the sync depth, so the sample lines up
      if (role == ROLE_SIDE_ADD && cur_ff.sclkSync && !cur_ff.sclkPrev) begin
         nxt_cur.sPos = cur_ff.padSync;  // [R9] [R10]
         nxt_cur.sNeg = cur_ff.negSync;
         nxt_cur.sV   = 1'b1;
      end

      // ----------------------------------------------------------
      // drop data cleared outside the drop role
      // ----------------------------------------------------------
      // stale bits from an earlier drop session never reach the pins
      if (role != ROLE_SIDE_DROP) begin
         nxt_cur.dPos = 1'b0;
         nxt_cur.dNeg = 1'b0;
      end

      // ----------------------------------------------------------
      // register writes
      // ----------------------------------------------------------
      // any write to the count word clears both counters
      if (regWr) begin
         if (regAddr == OFF_CTRL) begin
            nxt_cur.addEn  = regWrData[CTRL_ADD_EN];
            nxt_cur.mapper = regWrData[CTRL_MAPPER];
            nxt_cur.drop   = regWrData[CTRL_DROP];
         end else if (regAddr == OFF_COUNT) begin
            nxt_cur.addCnt  = 16'h0000;
            nxt_cur.hdlcCnt = 16'h0000;
         end
      end

      // ----------------------------------------------------------
      // register reads, unmapped addresses read zero
      // ----------------------------------------------------------
      // read data are registered and stand for one cycle only
      if (regRd) begin
         if (regAddr == OFF_CTRL) begin
            nxt_cur.rd = ctrlWord;
         end else if (regAddr == OFF_STATUS) begin
            nxt_cur.rd = statusWord;
         end else if (regAddr == OFF_COUNT) begin
            nxt_cur.rd = {cur_ff.hdlcCnt, cur_ff.addCnt};
         end
      end

      // ----------------------------------------------------------
      // synchronous reset
      // ----------------------------------------------------------
      if (!resetn) begin
         nxt_cur         = '0;
         nxt_cur.addEn   = RST_ADD_EN;
         nxt_cur.mapper  = RST_MAPPER;
         nxt_cur.drop    = RST_DROP;
      end
   end

   always_ff @(posedge clk) begin
      cur_ff <= nxt_cur;
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   // pin drives, enabled only in the side drop role
   assign padOut        = cur_ff.dPos;  // [R11]
   assign padOe         = (role == ROLE_SIDE_DROP);  // [R13]
   assign sideNegOut    = cur_ff.dNeg;
   assign sideNegOe     = (role == ROLE_SIDE_DROP);

   // generated clocks, held low outside their role
   assign sideClkOut    = cur_ff.genClk & (role == ROLE_SIDE_DROP);  // [R12]
   assign sideClkOe     = (role == ROLE_SIDE_DROP);
   assign hdlcByteClock = cur_ff.genClk & (role == ROLE_HDLC);  // [R6]

   // read data and samples toward the core
   assign regRdData     = cur_ff.rd;
   assign addByte       = cur_ff.addB;
   assign addByteValid  = cur_ff.addV;
   assign hdlcByte      = cur_ff.hdlcB;
   assign hdlcByteValid = cur_ff.hdlcV;
   assign sidePos       = cur_ff.sPos;
   assign sideNeg       = cur_ff.sNeg;
   assign sideValid     = cur_ff.sV;
   assign dropTake      = cur_ff.dTake;

endmodule

// ---- shared/pin_mux_pkg.sv ----
// shared constants and types for the channel 1 bit 3 shared pin mux
package pin_mux_pkg;

   // -------------------------------------------------------------
   // register map (byte addresses)
   // -------------------------------------------------------------
   localparam int          ADDR_W        = 4;
   localparam logic [3:0]  OFF_CTRL      = 4'h0;
   localparam logic [3:0]  OFF_STATUS    = 4'h4;
   localparam logic [3:0]  OFF_COUNT     = 4'h8;

   // -------------------------------------------------------------
   // control field positions and reset values
   // -------------------------------------------------------------
   localparam int          CTRL_ADD_EN   = 0;
   localparam int          CTRL_MAPPER   = 1;
   localparam int          CTRL_DROP     = 2;
   localparam logic        RST_ADD_EN    = 1'b0;
   localparam logic        RST_MAPPER    = 1'b0;
   localparam logic        RST_DROP      = 1'b0;

   // -------------------------------------------------------------
   // status field positions
   // -------------------------------------------------------------
   localparam int          ST_ROLE_LSB   = 0;
   localparam int          ST_PAD        = 2;
   localparam int          ST_SIDE_POS   = 3;
   localparam int          ST_SIDE_NEG   = 4;
   localparam int          ST_ADD_LSB    = 8;
   localparam int          ST_HDLC_LSB   = 16;

   // -------------------------------------------------------------
   // timing: half period of the generated byte / port clock
   // -------------------------------------------------------------
   localparam int          DIV_HALF      = 2;
   localparam int          DIV_W         = 8;

   typedef enum logic [1:0] {
      ROLE_ADD_BUS,
      ROLE_HDLC,
      ROLE_SIDE_ADD,
      ROLE_SIDE_DROP
   } role_t;

endpackage

// ---- logic/add_bus_capture.sv ----
// add bus byte capture on the falling edge of the add bus clock
`timescale 1ns/1ns
module add_bus_capture
   import pin_mux_pkg::*;
(
   input  wire logic       addBusClk,  // add bus clock from the far side
   input  wire logic       resetn,     // reset from the system domain
   input  wire logic       captureEn,  // add bus enable, system domain level
   input  wire logic [7:0] busByte,    // assembled add bus byte, raw pins
   input  wire logic       ackTgl,     // toggle from system domain
   output logic            reqTgl,     // toggles when a new byte is held
   output logic [7:0]      heldByte    // byte held until acknowledged
);

   typedef struct packed {
      logic       rstMeta;
      logic       rstSync;
      logic       enMeta;
      logic       enSync;
      logic       ackMeta;
      logic       ackSync;
      logic       req;
      logic [7:0] held;
   } cap_t;

   cap_t cur_ff;
   cap_t nxt_cur;

   // -------------------------------------------------------------
   // capture and handshake
   // -------------------------------------------------------------
   always_comb begin
      nxt_cur         = cur_ff;
      nxt_cur.rstMeta = resetn;
      nxt_cur.rstSync = cur_ff.rstMeta;
      nxt_cur.enMeta  = captureEn;
      nxt_cur.enSync  = cur_ff.enMeta;
      nxt_cur.ackMeta = ackTgl;
      nxt_cur.ackSync = cur_ff.ackMeta;
      if (!cur_ff.rstSync) begin
         nxt_cur.req  = 1'b0;
         nxt_cur.held = 8'h00;
      end else if (cur_ff.enSync && (cur_ff.req == cur_ff.ackSync)) begin
         nxt_cur.held = busByte;  // [R2] [R3]
         nxt_cur.req  = ~cur_ff.req;
      end
   end

   // falling edge latch of the add bus
   always_ff @(negedge addBusClk) begin
      cur_ff <= nxt_cur;  // [R3]
   end

   assign reqTgl   = cur_ff.req;
   assign heldByte = cur_ff.held;

endmodule

// ---- bench/pin_mux_assertions.sv ----
// port assertions for the shared pin mux
`timescale 1ns/1ns
module pin_mux_assertions (
   input wire logic clk,           // system clock
   input wire logic resetn,        // reset
   input wire logic padOut,        // pin value
   input wire logic padOe,         // pin enable
   input wire logic hdlcByteClock, // byte clock
   input wire logic sideNegOut,    // neg value
   input wire logic sideNegOe,     // neg enable
   input wire logic sideClkOut,    // port clock
   input wire logic sideClkOe,     // port clock enable
   input wire logic addByteValid,  // add pulse
   input wire logic hdlcByteValid, // hdlc pulse
   input wire logic dropPos,       // drop pos in
   input wire logic dropNeg,       // drop neg in
   input wire logic dropTake       // drop pulse
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_oe_group; padOe == sideNegOe && padOe == sideClkOe; endproperty
   a_oe_group: assert property (p_oe_group) else $error("pin enables disagree");
   property p_no_clk; padOe |-> !hdlcByteClock; endproperty
   a_no_clk: assert property (p_no_clk) else $error("byte clock in drop role");
   property p_hdlc_smp; $rose(hdlcByteClock) ##1 hdlcByteClock |=> hdlcByteValid; endproperty
   a_hdlc_smp: assert property (p_hdlc_smp) else $error("no byte after clock rise");
   property p_hdlc_pulse; hdlcByteValid |=> !hdlcByteValid; endproperty
   a_hdlc_pulse: assert property (p_hdlc_pulse) else $error("hdlc valid too long");
   property p_add_pulse; addByteValid |=> !addByteValid; endproperty
   a_add_pulse: assert property (p_add_pulse) else $error("add valid too long");
   property p_take_fall; dropTake |-> $fell(sideClkOut) && padOe; endproperty
   a_take_fall: assert property (p_take_fall) else $error("drop load off clock fall");
   property p_drop_load;
      dropTake |-> padOut == $past(dropPos) && sideNegOut == $past(dropNeg);
   endproperty
   a_drop_load: assert property (p_drop_load) else $error("drop value not loaded");
   property p_pad_hold; padOe && $past(padOe) && $changed(padOut) |-> $fell(sideClkOut); endproperty
   a_pad_hold: assert property (p_pad_hold) else $error("pin changed off clock fall");
   property p_drop_idle; !padOe && !$past(padOe) |-> !padOut && !sideNegOut; endproperty
   a_drop_idle: assert property (p_drop_idle) else $error("drop data left on idle pins");
endmodule
bind tx_ch1_bit3_pin_mux pin_mux_assertions u_pin_mux_assertions (.clk, .resetn, .padOut,
   .padOe, .hdlcByteClock, .sideNegOut, .sideNegOe, .sideClkOut, .sideClkOe, .addByteValid,
   .hdlcByteValid, .dropPos, .dropNeg, .dropTake);

// ---- bench/far_side_model.sv ----
// terminal equipment and tributary source facing the pin mux
`timescale 1ns/1ns
module far_side_model
   import pin_mux_pkg::*;
(
   input  wire logic       addBusClk,     // add bus clock
   input  wire logic       hdlcByteClock, // byte clock from device
   input  wire role_t      role,          // role being exercised
   input  wire logic [7:0] addData,       // byte to add
   input  wire logic [7:0] hdlcData,      // byte to send
   input  wire logic [1:0] sideData,      // pos, neg to add
   output logic [3:0]      addBusHi,      // add bits 7..4
   output logic [2:0]      addBusLo,      // add bits 2..0
   output logic [3:0]      hdlcHi,        // hdlc bits 7..4
   output logic [2:0]      hdlcLo,        // hdlc bits 2..0
   output logic            padDrv,        // shared pin drive
   output logic            sideNegDrv,    // neg pin drive
   output logic            sideClkDrv     // port clock drive
);
   logic [7:0] addQ = 8'h00;
   logic [7:0] hdlcQ = 8'h00;
   logic [1:0] sideQ = 2'h0;
   initial sideClkDrv = 1'b0;
   always @(posedge addBusClk) addQ <= addData;
   always @(negedge hdlcByteClock) hdlcQ <= hdlcData;
   always @(negedge sideClkDrv) sideQ <= sideData;
   // port clock runs only while adding
   always begin
      #100;
      sideClkDrv = (role == ROLE_SIDE_ADD) ? ~sideClkDrv : 1'b0;
   end
   assign addBusHi = addQ[7:4];
   assign addBusLo = addQ[2:0];
   assign hdlcHi = hdlcQ[7:4];
   assign hdlcLo = hdlcQ[2:0];
   assign padDrv = role == ROLE_ADD_BUS ? addQ[3] : role == ROLE_HDLC ? hdlcQ[3] : sideQ[1];
   assign sideNegDrv = sideQ[0];
endmodule

// ---- bench/tx_ch1_bit3_pin_mux_tb.sv ----
// self-checking bench for the shared pin mux
`timescale 1ns/1ns
module tx_ch1_bit3_pin_mux_tb;
   import pin_mux_pkg::*;
   logic clk = 1'b0, addBusClk = 1'b0, resetn, regWr, regRd, padIn, padOut, padOe;
   logic [ADDR_W-1:0] regAddr;
   logic [31:0] regWrData, regRdData, d, seed = 32'hF;
   logic [3:0] addBusHi, hdlcHi, ev;
   logic [2:0] addBusLo, hdlcLo;
   logic hdlcByteClock, sideNegIn, sideNegOut, sideNegOe, sideClkIn, sideClkOut, sideClkOe;
   logic addByteValid, hdlcByteValid, sidePos, sideNeg, sideValid, dropPos, dropNeg, dropTake;
   logic padDrv, sideNegDrv, sideClkDrv;
   logic [7:0] addByte, hdlcByte, addData, hdlcData;
   logic [1:0] sideData, pn;
   role_t role;
   int error_cnt = 0, comparisons = 0, cyc = 0;
   always #20 clk = ~clk;
   always #16 addBusClk = ~addBusClk;
   assign padIn = padOe ? padOut : padDrv;
   assign sideNegIn = sideNegOe ? sideNegOut : sideNegDrv;
   assign sideClkIn = sideClkOe ? sideClkOut : sideClkDrv;
   assign ev = {dropTake, sideValid, hdlcByteValid, addByteValid};
   tx_ch1_bit3_pin_mux u_tx_ch1_bit3_pin_mux (.clk, .resetn, .regAddr, .regWrData, .regWr,
      .regRd, .regRdData, .padIn, .padOut, .padOe, .addBusClk, .addBusHi, .addBusLo, .hdlcHi,
      .hdlcLo, .hdlcByteClock, .sideNegIn, .sideNegOut, .sideNegOe, .sideClkIn, .sideClkOut,
      .sideClkOe, .addByte, .addByteValid, .hdlcByte, .hdlcByteValid, .sidePos, .sideNeg,
      .sideValid, .dropPos, .dropNeg, .dropTake);
   far_side_model u_far_side_model (.addBusClk, .hdlcByteClock, .role, .addData, .hdlcData,
      .sideData, .addBusHi, .addBusLo, .hdlcHi, .hdlcLo, .padDrv, .sideNegDrv, .sideClkDrv);
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   // n pulses of event k, bounded
   task automatic waitEv(input int k, input int n);
      int t;
      for (int i = 0; i < n; i++) begin
         t = 0;
         do begin
            @(posedge clk);
            #1 t++;
         end while (ev[k] !== 1'b1 && t < 300);
         if (t >= 300) chk("wait", 32'h0, 32'h1);
      end
   endtask
   task automatic results();
      if (error_cnt == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end
   initial begin
      {resetn, regWr, regRd, dropPos, dropNeg, regAddr, regWrData} = '0;
      {addData, hdlcData, sideData} = '0;
      role = ROLE_HDLC;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      rd(OFF_CTRL);
      chk("ctrl", d, 32'h0);
      rd(OFF_STATUS);
      chk("role hdlc", d[1:0], 32'h1);
      rd(4'hC);
      chk("unmapped", d, 32'h0);
      repeat (4) begin
         hdlcData = xs();
         waitEv(1, 3);
         chk("hdlc byte", hdlcByte, hdlcData);
         chk("hdlc oe", padOe, 32'h0);
      end
      role = ROLE_ADD_BUS;
      wr(OFF_CTRL, 32'h7);
      repeat (4) begin
         addData = xs();
         waitEv(0, 4);
         chk("add byte", addByte, addData);
         chk("byte clock", hdlcByteClock, 32'h0);
      end
      rd(OFF_STATUS);
      chk("role add", d[1:0], 32'h0);
      chk("status add", d[15:8], addData);
      chk("add oe", padOe, 32'h0);
      role = ROLE_SIDE_ADD;
      wr(OFF_CTRL, 32'h2);
      for (int i = 0; i < 4; i++) begin
         sideData = 2'(i);
         waitEv(2, 3);
         chk("side add", {sidePos, sideNeg}, sideData);
      end
      rd(OFF_STATUS);
      chk("role side add", d[1:0], 32'h2);
      role = ROLE_SIDE_DROP;
      wr(OFF_CTRL, 32'h6);
      rd(OFF_STATUS);
      chk("role drop", d[1:0], 32'h3);
      repeat (6) begin
         pn = 2'(xs());
         @(posedge clk);
         dropPos <= pn[1];
         dropNeg <= pn[0];
         waitEv(3, 1);
         chk("drop pins", {padOe, padIn, sideNegIn}, {1'b1, pn});
      end
      rd(OFF_COUNT);
      chk("counts run", {d[31:16] != 16'h0, d[15:0] != 16'h0}, 32'h3);
      wr(OFF_COUNT, 32'h0);
      rd(OFF_COUNT);
      chk("count", d, 32'h0);
      results();
   end
endmodule
